// *** hw/cls_speed_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Demand is input duty times top speed
// - Top speed is 0.1*(2^(sel+8)-1) Hz
// - Compare demand to speed, adjust bridge duty
// - Bridge PWM period set by period select
// - Current limiter off time is one period
// - Limiter resumes on-state only when bridge duty asks for it
// - Separate proportional and integral gain fields
// - Inactive beyond two periods forces bridge off
// - One more period inactive brakes if enabled
// - After enable, brake held until duty above 10%
// - Brake enable cleared means never brake
// - Brake only from 0%, not running motor
// - After brake, 10-25% duty lets motor coast
// - Duty above 25% starts the motor
// - Ignore demand until two commutations after hold
// - Inactive input during start brakes if enabled, else coasts
// - Below quarter start speed, bridge off, coast
// - Fault low three periods, high three periods
// - Auto restart after two fault cycles
// - No restart: signal until duty<25% or stop
module cls_speed_ctrl
  import cls_pkg::*;
#(
  parameter int CW      = 24,
  parameter int SPD_WIN = SPD_WIN_CYC
) (
  input  wire logic           clk,
  input  wire logic           resetn,
  input  wire cls_wb_req_type wb_req,
  output logic                wb_ack,
  output logic [31:0]         wb_dat_o,
  input  wire logic           pwm_in,
  input  wire logic           ilim_in,
  input  wire logic           elec_cycle_tick,
  input  wire logic           commutation_tick,
  input  wire logic           hold_done,
  output logic                start_request,
  output cls_bridge_type      bridge,
  output logic                fault_output_low,
  output logic                fault_oe
);
  // ----------------------------------------
  // Registers and pin synchroniser
  // ----------------------------------------
  cls_ctrl_type  ctrl;       // Run, brake, restart
  cls_cfg_type   cfg;        // Speed and loop setup
  cls_state_type st;         // Motor state
  logic [1:0]    sync1;      // First stage only
  logic [1:0]    sync2;      // Safe copies
  logic          pwm_s;
  logic          ilim_s;
  logic          pwm_q;      // Edge history
  logic          rise;
  // Pins are asynchronous to clk
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
    end else begin
      sync1 <= {pwm_in, ilim_in};
      sync2 <= sync1;
    end
  end
  assign pwm_s  = sync2[1];
  assign ilim_s = sync2[0];
  assign rise   = pwm_s & ~pwm_q;
  // ----------------------------------------
  // Input duty measurement
  // ----------------------------------------
  logic [CW-1:0] per_cnt, next_per_cnt;   // Running period
  logic [CW-1:0] hi_cnt, next_hi_cnt;     // Running high
  logic [CW+1:0] lo_cnt, next_lo_cnt;     // Inactive time
  logic [CW-1:0] per, next_per;           // Last period
  logic [CW:0]   rem, next_rem;           // Divider rest
  logic [CW:0]   rem2;
  logic [7:0]    quo, next_quo;
  logic [3:0]    step, next_step;
  logic [7:0]    duty, next_duty;         // Input duty /256
  logic          idle;                    // Bridge forced off
  logic          brk_t, brk_q;            // Brake timeout
  logic          idle_evt;
  logic [CW+1:0] per2, per3;
  assign per2     = {1'b0, per, 1'b0};
  assign per3     = per2 + {2'b0, per};
  assign idle     = ~pwm_s && per != '0 && lo_cnt > per2;
  assign brk_t    = ~pwm_s && per != '0 && lo_cnt > per3;
  assign idle_evt = brk_t & ~brk_q;
  assign rem2     = {rem[CW-1:0], 1'b0};
  // Counters saturate so a stuck pin never wraps
  always_comb begin
    next_per_cnt = rise ? CW'(1) : per_cnt + CW'(~&per_cnt);
    next_hi_cnt  = rise ? CW'(1)
                 : hi_cnt + CW'(pwm_s & ~&hi_cnt);
    next_lo_cnt  = pwm_s ? '0 : lo_cnt + (CW+2)'(~&lo_cnt);
    next_per  = per;
    next_rem  = rem;
    next_quo  = quo;
    next_step = step;
    next_duty = duty;
    if (rise) begin
      next_per = per_cnt;
      if (hi_cnt >= per_cnt) begin
        next_duty = DUTY_FULL;
        next_step = 4'h0;
      end else begin
        next_rem  = {1'b0, hi_cnt};
        next_quo  = 8'h00;
        next_step = 4'h8;
      end
    end else if (step != 4'h0) begin
      // Restoring divide, one bit per cycle
      if (rem2 >= {1'b0, per}) begin
        next_rem = rem2 - {1'b0, per};
        next_quo = {quo[6:0], 1'b1};
      end else begin
        next_rem = rem2;
        next_quo = {quo[6:0], 1'b0};
      end
      next_step = step - 4'h1;
      if (step == 4'h1) begin
        next_duty = next_quo;
      end
    end
    if (idle) begin
      next_duty = 8'h00;                       // Input counts as 0%
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      per_cnt <= '0;
      hi_cnt  <= '0;
      lo_cnt  <= '0;
      per     <= '0;
      rem     <= '0;
      quo     <= 8'h00;
      step    <= 4'h0;
      duty    <= 8'h00;
      pwm_q   <= 1'b0;
      brk_q   <= 1'b0;
    end else begin
      per_cnt <= next_per_cnt;
      hi_cnt  <= next_hi_cnt;
      lo_cnt  <= next_lo_cnt;
      per     <= next_per;
      rem     <= next_rem;
      quo     <= next_quo;
      step    <= next_step;
      duty    <= next_duty;
      pwm_q   <= pwm_s;
      brk_q   <= brk_t;
    end
  end
  // ----------------------------------------
  // Speed measurement and demand
  // ----------------------------------------
  logic [23:0] win, next_win;
  logic [11:0] ecnt, next_ecnt;   // Cycles this window
  logic [11:0] meas, next_meas;   // Cycles last window
  logic        win_tick;
  logic [15:0] fmax;
  logic [23:0] dprod;
  logic [15:0] demand;            // 0.1 Hz units
  logic [16:0] meas_dhz;
  logic [15:0] ss_dhz;
  logic        low_spd;
  assign win_tick = win == 24'(SPD_WIN - 1);
  // Exponent needs four bits: select plus eight reaches 15
  assign fmax = 16'((17'h1 << (4'(cfg.top_speed_select)
                + 4'(FMAX_EXP))) - 17'h1);
  assign dprod    = duty * fmax;
  assign demand   = dprod[23:8];
  assign meas_dhz = 17'(meas * MEAS_TO_DHZ);
  assign ss_dhz   = 16'((cfg.start_speed_select + 3'h1)
                    * SS_STEP);
  assign low_spd  = meas_dhz < {3'h0, ss_dhz[15:2]}
                 || demand < {2'h0, ss_dhz[15:2]};
  always_comb begin
    next_win  = win_tick ? '0 : win + 24'h1;
    next_ecnt = win_tick ? '0
              : ecnt + 12'(elec_cycle_tick & ~&ecnt);
    next_meas = win_tick ? ecnt : meas;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      win  <= '0;
      ecnt <= '0;
      meas <= '0;
    end else begin
      win  <= next_win;
      ecnt <= next_ecnt;
      meas <= next_meas;
    end
  end
  // ----------------------------------------
  // Motor state sequencer
  // ----------------------------------------
  cls_state_type next_st;
  logic [1:0] comm, next_comm;     // Commutations after hold
  logic       held, next_held;
  logic [1:0] lcnt, next_lcnt;     // Periods in fault half
  logic       lph, next_lph;       // 0 = fault pin low
  logic [1:0] lrep, next_lrep;     // Full fault cycles
  logic       run_q;
  logic       may_brk;
  logic       restart;
  // Brake needs both bits, never without enable
  assign may_brk = ctrl.brake_enable_bit & ctrl.run;
  assign restart = ctrl.run & ctrl.auto_restart_enable
                 & duty > DUTY_25;
  always_comb begin
    next_st   = st;
    next_comm = comm;
    next_held = held;
    next_lcnt = lcnt;
    next_lph  = lph;
    next_lrep = lrep;
    case (st)
      CLS_BRAKE: begin
        if (!may_brk) begin
          next_st = CLS_COAST;
        end else if (duty > DUTY_25) begin
          next_st = CLS_START;
        end else if (duty >= DUTY_10) begin
          next_st = CLS_COAST;
        end
      end
      CLS_COAST: begin
        if (idle_evt && may_brk) begin
          next_st = CLS_BRAKE;
        end else if (ctrl.run && !run_q && may_brk
                     && duty < DUTY_10) begin
          next_st = CLS_BRAKE;
        end else if (ctrl.run && duty > DUTY_25) begin
          next_st = CLS_START;
        end
      end
      CLS_START: begin
        // Demand ignored until two commutations
        if (hold_done) begin
          next_held = 1'b1;
        end
        if (held && commutation_tick) begin
          next_comm = comm + 2'h1;
        end
        if (idle_evt) begin
          next_st = may_brk ? CLS_BRAKE : CLS_COAST;
        end else if (!ctrl.run) begin
          next_st = CLS_COAST;
        end else if (comm == START_COMM) begin
          next_st = CLS_RUN;
        end
      end
      CLS_RUN: begin
        if (idle_evt) begin
          next_st = may_brk ? CLS_BRAKE : CLS_COAST;
        end else if (!ctrl.run) begin
          next_st = CLS_COAST;
        end else if (win_tick && low_spd) begin
          next_st = CLS_LOS;
        end
      end
      CLS_LOS: begin
        if (rise) begin
          next_lcnt = lcnt + 2'h1;
          if (lcnt == LOS_HALF - 2'h1) begin
            next_lcnt = 2'h0;
            next_lph  = ~lph;
            if (lph) begin
              next_lrep = lrep + 2'h1;
            end
          end
        end
        if (idle_evt) begin
          next_st = may_brk ? CLS_BRAKE : CLS_COAST;
        end else if (ctrl.auto_restart_enable) begin
          if (!restart) begin
            next_st = CLS_COAST;
          end else if (next_lrep == LOS_REPS) begin
            next_st = CLS_START;
          end
        end else if (duty < DUTY_25 || !ctrl.run) begin
          next_st = CLS_COAST;
        end
      end
      default: next_st = CLS_COAST;
    endcase
    if (next_st != st) begin
      // Fresh counts on every state entry
      next_comm = 2'h0;
      next_held = 1'b0;
      next_lcnt = 2'h0;
      next_lph  = 1'b0;
      next_lrep = 2'h0;
    end
  end
  // Power-on lands in brake; it drops out unless enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st    <= CLS_BRAKE;
      comm  <= 2'h0;
      held  <= 1'b0;
      lcnt  <= 2'h0;
      lph   <= 1'b0;
      lrep  <= 2'h0;
      run_q <= 1'b0;
    end else begin
      st    <= next_st;
      comm  <= next_comm;
      held  <= next_held;
      lcnt  <= next_lcnt;
      lph   <= next_lph;
      lrep  <= next_lrep;
      run_q <= ctrl.run;
    end
  end
  // ----------------------------------------
  // PI loop and bridge PWM
  // ----------------------------------------
  logic signed [17:0] err;
  logic signed [25:0] isum, osum;
  logic signed [25:0] integ, next_integ;
  logic [7:0]  bdu, next_bdu;      // Bridge duty /256
  logic [11:0] bper;               // Bridge period
  logic [11:0] bcnt, next_bcnt;
  logic [11:0] boff, next_boff;    // Limiter off time
  logic [19:0] bprod;
  logic        bcmp;
  assign err  = $signed({2'b0, demand})
              - $signed({1'b0, meas_dhz});
  assign isum = integ + 26'(err <<< cfg.int_gain_select);
  assign osum = (integ + 26'(err <<< cfg.prop_gain_select))
                >>> INT_SHIFT;
  assign bper = 12'((cfg.bridge_period_select + 5'h1)
              * PW_STEP_CYC);
  assign bprod = bdu * bper;
  assign bcmp  = bcnt < bprod[19:8];
  always_comb begin
    next_integ = integ;
    next_bdu   = bdu;
    next_bcnt  = (bcnt >= bper - 12'h1) ? '0
               : bcnt + 12'h1;
    next_boff  = boff;
    if (st == CLS_START) begin
      next_bdu   = START_DUTY;
      next_integ = 26'(START_DUTY) <<< INT_SHIFT;
    end else if (st == CLS_RUN) begin
      if (win_tick) begin
        next_integ = isum < 0 ? '0 : isum;
        next_bdu   = osum < 0 ? 8'h00
                   : osum > 26'(DUTY_FULL) ? DUTY_FULL
                   : osum[7:0];
      end
    end else begin
      next_bdu = 8'h00;
    end
    // Off time equals one bridge period
    if (boff != '0) begin
      next_boff = boff - 12'h1;
    end else if (ilim_s && bcmp) begin
      next_boff = bper;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      integ <= '0;
      bdu   <= 8'h00;
      bcnt  <= '0;
      boff  <= '0;
    end else begin
      integ <= next_integ;
      bdu   <= next_bdu;
      bcnt  <= next_bcnt;
      boff  <= next_boff;
    end
  end
  // Limiter only re-enters on-state when duty asks for it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bridge           <= '0;
      fault_oe         <= 1'b0;
      start_request    <= 1'b0;
    end else begin
      bridge.enable <= (next_st == CLS_START
                     || next_st == CLS_RUN) && !idle;
      bridge.pwm_on <= bcmp && next_boff == '0
                     && !idle;
      bridge.brake  <= next_st == CLS_BRAKE;
      fault_oe      <= next_st == CLS_LOS
                     && !next_lph;
      start_request <= next_st == CLS_START
                     && st != CLS_START;
    end
  end
  assign fault_output_low = 1'b0;  // Open drain, pull only
  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  logic wb_hit;
  logic wb_wr;
  assign wb_hit = wb_req.cyc & wb_req.stb & ~wb_ack;
  // Write lands at the edge where the master sees ack
  assign wb_wr  = wb_req.cyc & wb_req.stb & wb_req.we & wb_ack;
  // One wait state; unmapped reads return zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack   <= 1'b0;
      wb_dat_o <= '0;
      ctrl     <= CTRL_RST;
      cfg      <= CFG_RST;
    end else begin
      wb_ack   <= wb_hit;
      wb_dat_o <= '0;
      if (wb_wr && wb_req.sel[0]) begin
        if (wb_req.adr == ADR_CTRL) begin
          ctrl <= wb_req.dat[2:0];
        end
      end
      if (wb_wr && wb_req.adr == ADR_CFG) begin
        if (wb_req.sel[0]) cfg[7:0]   <= wb_req.dat[7:0];
        if (wb_req.sel[1]) cfg[15:8]  <= wb_req.dat[15:8];
        if (wb_req.sel[2]) cfg[20:16] <= wb_req.dat[20:16];
      end
      if (wb_hit && !wb_req.we) begin
        case (wb_req.adr)
          ADR_CTRL:  wb_dat_o <= {29'h0, ctrl};
          ADR_CFG:   wb_dat_o <= {11'h0, cfg};
          ADR_STAT:  wb_dat_o <= {8'h0, bdu, duty,
                                  4'h0, fault_oe, st};
          ADR_SPEED: wb_dat_o <= {20'h0, meas};
          default:   wb_dat_o <= '0;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  idle_bridge_off_a: assert property (
    @(posedge clk) disable iff (!resetn)
    idle |=> !bridge.pwm_on && !bridge.enable)
    else $error("bridge driven while input idle");
  no_brake_dis_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !ctrl.brake_enable_bit |=> !bridge.brake)
    else $error("brake with brake enable clear");
  start_abort_a: assert property (
    @(posedge clk) disable iff (!resetn)
    st == CLS_START && idle_evt && may_brk |=> st == CLS_BRAKE)
    else $error("start not aborted to brake");
  start_go_a: assert property (
    @(posedge clk) disable iff (!resetn)
    st == CLS_COAST && ctrl.run && duty > DUTY_25 && !idle_evt
    |=> st == CLS_START && start_request)
    else $error("start not initiated");
  start_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    st == CLS_START && comm != START_COMM |=> st != CLS_RUN)
    else $error("run before two commutations");
  limit_off_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(boff != '0) |-> boff == bper)
    else $error("limiter off time wrong");
  los_coast_a: assert property (
    @(posedge clk) disable iff (!resetn)
    st == CLS_LOS |-> !bridge.enable)
    else $error("bridge on during sync loss");
  fault_stop_a: assert property (
    @(posedge clk) disable iff (!resetn)
    st == CLS_LOS && !ctrl.auto_restart_enable && !idle_evt
    && !ctrl.run |=> st == CLS_COAST ##1 !fault_oe)
    else $error("fault kept after run cleared");
endmodule : cls_speed_ctrl
`default_nettype wire

// *** common/cls_pkg.sv ***
`default_nettype none
package cls_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_NS       = 40;
  localparam int SPD_WIN_NS   = 100_000_000;
  localparam int SPD_WIN_CYC  = SPD_WIN_NS / CLK_NS;
  localparam int PW_STEP_NS   = 4000;
  localparam int PW_STEP_CYC  = PW_STEP_NS / CLK_NS;
  // One window count is 10 Hz, i.e. 100 units of 0.1 Hz
  localparam int MEAS_TO_DHZ  = 100;
  // ----------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------
  localparam logic [3:0] ADR_CTRL  = 4'h0;
  localparam logic [3:0] ADR_CFG   = 4'h4;
  localparam logic [3:0] ADR_STAT  = 4'h8;
  localparam logic [3:0] ADR_SPEED = 4'hC;
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [20:0] CFG_RST  = 21'h000000;
  // ----------------------------------------
  // Speed scaling and thresholds
  // ----------------------------------------
  localparam int         FMAX_EXP   = 8;
  localparam logic [7:0] SS_STEP    = 8'h32;
  localparam logic [7:0] DUTY_10    = 8'h1A;
  localparam logic [7:0] DUTY_25    = 8'h40;
  localparam logic [7:0] DUTY_FULL  = 8'hFF;
  localparam logic [7:0] START_DUTY = 8'h40;
  localparam int         INT_SHIFT  = 10;
  localparam logic [1:0] LOS_HALF   = 2'h3;
  localparam logic [1:0] LOS_REPS   = 2'h2;
  localparam logic [1:0] START_COMM = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    CLS_BRAKE, CLS_COAST, CLS_START, CLS_RUN, CLS_LOS
  } cls_state_type;
  typedef struct packed {
    logic auto_restart_enable;
    logic brake_enable_bit;
    logic run;
  } cls_ctrl_type;
  typedef struct packed {
    logic [2:0] start_speed_select;
    logic [2:0] int_gain_select;
    logic [2:0] prop_gain_select;
    logic [4:0] bridge_period_select;
    logic [2:0] top_speed_select;
    logic [3:0] spare;
  } cls_cfg_type;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cls_wb_req_type;
  typedef struct packed {
    logic enable;
    logic pwm_on;
    logic brake;
  } cls_bridge_type;
endpackage : cls_pkg
`default_nettype wire

// *** verification/cls_pwm_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Speed controller stand-in on the pwm pin
// ----------------------------------------
module cls_pwm_src (
  input  wire logic        clk,
  input  wire logic        active,
  input  wire logic [15:0] period,
  input  wire logic [15:0] high,
  output logic             pwm
);
  logic [15:0] cnt = 16'h0000; // Position in the period
  // Steady period, so no duty error creeps in
  // Period far shorter than a real source: keeps runs brief
  always @(posedge clk) begin
    cnt <= (cnt >= period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
    pwm <= active && (cnt < high); // Idle is the inactive level
  end
endmodule : cls_pwm_src
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cls_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic           clk, resetn;
  cls_wb_req_type req;         // Bus request
  logic           wb_ack;
  logic [31:0]    wb_dat;
  logic           pwm, act;    // Input pin and source enable
  logic           ect, ctk, hdn, sreq, foe, flo;
  cls_bridge_type br;
  logic [15:0]    per, hi;     // Source period and high time
  logic           elec_en;     // Motor turning
  logic [4:0]     ecnt;        // Tick spacing
  logic [31:0]    seed;        // Random state
  logic [31:0]    lf;          // Random state for the limiter
  logic           ilim;        // Current limit comparator
  logic [31:0]    exp_q[$];    // Expected read data
  logic [31:0]    msk_q[$];    // Bits that matter
  int             failures, n_compared, n;

  cls_speed_ctrl #(.SPD_WIN(1000)) u_dut (
    .clk(clk), .resetn(resetn), .wb_req(req), .wb_ack(wb_ack),
    .wb_dat_o(wb_dat), .pwm_in(pwm), .ilim_in(ilim),
    .elec_cycle_tick(ect), .commutation_tick(ctk), .hold_done(hdn),
    .start_request(sreq), .bridge(br), .fault_output_low(flo),
    .fault_oe(foe));
  cls_pwm_src u_src (.clk(clk), .active(act), .period(per),
    .high(hi), .pwm(pwm));

  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Electrical cycle ticks while the motor turns
  always @(posedge clk) begin
    ecnt <= ecnt + 5'h01;
    ect  <= elec_en && (ecnt == 5'h00);
    // Current limit trips at random while the motor turns
    lf   <= lfsr(lf);
    ilim <= elec_en && (lf[2:0] == 3'h0);
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask : tend
  // Classic cycle; held until ack, released at that edge
  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do begin
      @(posedge clk);
      i++;
    end while (wb_ack !== 1'b1 && i < 100);
    if (wb_ack !== 1'b1) begin
      failures++;
      finish_test();
    end
    req <= '0;
  endtask : bus
  // Note the expectation, then read
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Bounded wait on start request (0) or fault enable (1)
  task automatic wt(input int s, input logic lv, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while ((s ? foe : sreq) !== lv && c < 5000);
    if (c >= 5000) begin
      failures++;
      finish_test();
    end
  endtask : wt
  // Stop the source just after a falling edge
  task automatic stop();
    for (n = 0; n < 600 && pwm !== 1'b1; n++) @(posedge clk);
    if (n < 600) begin
      for (n = 0; n < 600 && pwm !== 1'b0; n++) @(posedge clk);
    end
    if (n >= 600) begin
      failures++;
      finish_test();
    end
    act <= 1'b0;
  endtask : stop
  task automatic pulse(input int s);
    @(posedge clk);
    if (s) ctk <= 1'b1; else hdn <= 1'b1;
    @(posedge clk);
    ctk <= 1'b0;
    hdn <= 1'b0;
  endtask : pulse
  // Half duty start, hold, two commutations
  task automatic go();
    hi  <= 16'h00FA;
    act <= 1'b1;
    wt(0, 1'b1, n);
    chk("start enable", br.enable, 32'h1);
    pulse(0);
    pulse(1);
    rd(ADR_STAT, 32'h2, 32'h7);
    pulse(1);
    rd(ADR_STAT, 32'h3, 32'h7);
  endtask : go
  // Read checker: oldest note against each read answer
  always @(posedge clk) begin
    if (wb_ack === 1'b1 && req.we === 1'b0 && exp_q.size() > 0) begin
      chk("read data", wb_dat & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    req = '0; act = 1'b0; per = 16'h01F4; hi = 16'h0000;
    ctk = 1'b0; hdn = 1'b0; elec_en = 1'b1; ecnt = 5'h00;
    lf = 32'hF272AAC7;
    resetn = 1'b0; failures = 0; n_compared = 0;
    seed = 32'hF272AAC7;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(ADR_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(ADR_CFG, 32'h0, 32'hFFFFFFFF);
    rd(ADR_STAT, 32'h1, 32'h7);
    bus(1'b1, 4'h2, 32'hFFFFFFFF);           // Unmapped
    rd(4'h2, 32'h0, 32'hFFFFFFFF);
    seed = lfsr(seed);
    bus(1'b1, ADR_CFG, seed);
    rd(ADR_CFG, seed, 32'h001FFFF0);
    bus(1'b1, ADR_CFG, 32'h0);
    tend("registers");
    bus(1'b1, ADR_CTRL, 32'h3);
    rd(ADR_STAT, 32'h0, 32'h7);
    hi  <= 16'h004B;                         // 15 percent
    act <= 1'b1;
    repeat (2000) @(posedge clk);
    rd(ADR_STAT, 32'h1, 32'h7);
    chk("coast enable", br.enable, 32'h0);
    go();
    stop();
    repeat (1100) @(posedge clk);
    chk("idle pwm_on", br.pwm_on, 32'h0);
    chk("idle enable", br.enable, 32'h0);
    repeat (500) @(posedge clk);
    chk("idle brake", br.brake, 32'h1);
    rd(ADR_STAT, 32'h0, 32'h7);
    tend("run and brake");
    act <= 1'b1;
    wt(0, 1'b1, n);
    stop();
    repeat (1600) @(posedge clk);
    chk("abort brake", br.brake, 32'h1);
    bus(1'b1, ADR_CTRL, 32'h1);
    act <= 1'b1;
    wt(0, 1'b1, n);
    stop();
    repeat (1600) @(posedge clk);
    chk("no brake", br.brake, 32'h0);
    tend("abort");
    bus(1'b1, ADR_CTRL, 32'h5);
    go();
    elec_en <= 1'b0;                         // Motor stalls
    wt(1, 1'b1, n);
    rd(ADR_STAT, 32'h4, 32'h7);
    chk("lost enable", br.enable, 32'h0);
    chk("pin value", flo, 32'h0);
    wt(1, 1'b0, n);
    wt(1, 1'b1, n);
    chk("fault release", 32'(n), 32'h5DC);
    wt(0, 1'b1, n);
    rd(ADR_STAT, 32'h2, 32'h7);
    tend("loss of sync");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
